// [rtl/irt_consts.vh]
`ifndef IRT_CONSTS_VH
`define IRT_CONSTS_VH

// Register indices on the plain register port.
`define IRT_ADDR_SHORT_CTRL 3'h0
`define IRT_ADDR_SHARED_CTRL 3'h1
`define IRT_ADDR_LONG_CTRL 3'h2
`define IRT_ADDR_SYNC_CTRL 3'h3
`define IRT_ADDR_SHORT_RELOAD_HIGH 3'h4
`define IRT_ADDR_SHORT_RELOAD_LOW 3'h5
`define IRT_ADDR_LONG_RELOAD_UPPER 3'h6
`define IRT_ADDR_LONG_RELOAD_LOWER 3'h7
// Capture registers use the second bank (address bit 3 set).
`define IRT_ADDR_SHORT_CAP_RISE 4'h8
`define IRT_ADDR_SHORT_CAP_FALL 4'h9
`define IRT_ADDR_LONG_CAP_UPPER 4'hA
`define IRT_ADDR_LONG_CAP_LOWER 4'hB

// Control bit positions.
`define IRT_BIT_ENABLE 7
`define IRT_BIT_ONESHOT 6
`define IRT_BIT_TIMEOUT 5
`define IRT_BIT_CAP_IE 2
`define IRT_BIT_TMO_IE 1
`define IRT_BIT_PIN_SEL 0
`define IRT_BIT_MODE 7
`define IRT_BIT_RX_SEL 6
`define IRT_BIT_SYNC 5
`define IRT_SYNC_RESERVED 5'h1F

// Transmit submode codes.
`define IRT_SUB_NORMAL 2'h0
`define IRT_SUB_ALT 2'h1
`define IRT_SUB_FORCE0 2'h2
`define IRT_SUB_FORCE1 2'h3

// Edge selection codes.
`define IRT_EDGE_FALL 2'h0
`define IRT_EDGE_RISE 2'h1
`define IRT_EDGE_BOTH 2'h2

// Glitch filter widths in counter-clock cycles.
`define IRT_GLITCH_SHORT 4'h4
`define IRT_GLITCH_LONG 4'h8

`endif

// [rtl/irt_dual_counter_timer.v]
// Notes on behaviour
// (R1) Transmit: long one-shot bit 0 reloads at terminal count, 1 halts.
// (R2) Demodulation: bit 0 captures every edge; 1 captures first edge only.
// (R3) Long expiry flag sets at terminal count; cleared by writing 1 only.
// (R4) Capture and expiry interrupt-allow bits each gate their own source of the one long-counter request.
// (R5) Pin-select bit puts port data or long output on second timer pin.
// (R6) Sync register: long enable bit 7, short 6, lockstep 5, low bits read ones.
// (R7) Input stage picks receive pin, detects chosen edges, filters narrow glitches.
// (R8) Short output idles inverted; on enable takes initial level and loads reload.
// (R9) Short one-shot counts to zero, stops, toggles, sets expiry, may interrupt.
// (R10) Short modulo-N toggles each terminal count; expiry once per two phases.
// (R11) Reload registers writable anytime; new values used at next load.
// (R12) Start count 1 forbidden; zero wraps to all ones without expiry.
// (R13) Software stops counters and clears flags in separate writes.
// (R14) Software sets all reloads to ones before demodulation.
// (R15) Short demod: start on first edge, capture complement by edge kind, restart.
// (R16) Demodulation: zero sets expiry, may interrupt, continues from all ones.
// (R17) Long output idles inverted; submodes 10 and 11 force its level on the second timer pin to 0 or 1, not long_output_o.
// (R18) Long enable loads upper*256+lower; zero toggles, expires, halts or reloads.
// (R19) Long demod, ignore clear: capture on each later edge and reload all ones.
// (R20) Ignore set: later edges ignored, short timeout captures, rewrite re-arms.
// (R21) Alternating mode hands off between one-shot counters; submode 00 stops it.
// (R22) Software disables counters and clears flags before alternating mode.
// (R23) Shared mode bit: 0 transmit, 1 demodulation for both counters.
// (R24) Enabled counters decrement per prescaled tick and hold when disabled.
`timescale 1ns/1ps
`default_nettype none
`include "irt_consts.vh"

module irt_dual_counter_timer #(
	parameter SHORT_W = 8,
	parameter LONG_W = 16
) (
	// Clock and reset.
	input wire clk_i,
	input wire rst_i,
	// Register port.
	input wire [3:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	// Pins.
	input wire receive_pin_a_i,
	input wire receive_pin_b_i,
	input wire port_data_i,
	output reg second_timer_pin_o,
	output reg short_output_o,
	output reg long_output_o,
	// Interrupt requests.
	output wire short_irq_o,
	output wire long_irq_o
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	reg short_en_reg, short_oneshot_reg, short_tmo_reg, short_cap_ie_reg, short_tmo_ie_reg;
	reg [1:0] short_pre_reg;
	reg long_en_reg, long_oneshot_reg, long_tmo_reg, long_cap_ie_reg, long_tmo_ie_reg, long_pin_select_reg;
	reg [1:0] long_prescale_select_reg;
	reg mode_reg, rx_sel_reg, sync_reg, init_short_reg, init_long_reg, rise_flag_reg, fall_flag_reg;
	reg [1:0] logic_edge_reg, submode_reg;
	reg [SHORT_W-1:0] short_reload_high_reg, short_reload_low_reg, short_count_reg;
	reg [SHORT_W-1:0] short_capture_rise_reg, short_capture_fall_reg;
	reg [7:0] long_reload_upper_reg, long_reload_lower_reg, long_capture_upper_reg, long_capture_lower_reg;
	reg [LONG_W-1:0] long_count_reg;
	reg short_phase_reg, short_started_reg, long_started_reg, long_armed_reg;
	reg short_irq_reg, long_irq_reg;
	reg [2:0] pre_reg;
	reg [3:0] glitch_cnt_reg;
	reg rx_filt_reg, rx_prev_reg;

	wire demod = mode_reg; // (R23)
	wire [SHORT_W-1:0] s_ones = {SHORT_W{1'b1}};
	wire [LONG_W-1:0] l_ones = {LONG_W{1'b1}};
	wire [LONG_W-1:0] long_reload = {long_reload_upper_reg, long_reload_lower_reg}; // (R18)
	wire alt_mode = !demod && submode_reg == `IRT_SUB_ALT;

	// ------------------------------------------------------------
	// Prescaler ticks
	// ------------------------------------------------------------
	function tick_sel;
		input [1:0] sel;
		input [2:0] cnt;
		begin
			case (sel)
				2'd0: tick_sel = 1'b1;
				2'd1: tick_sel = cnt[0];
				2'd2: tick_sel = &cnt[1:0];
				default: tick_sel = &cnt;
			endcase
		end
	endfunction

	wire short_tick = tick_sel(short_pre_reg, pre_reg);
	wire long_tick = tick_sel(long_prescale_select_reg, pre_reg);

	// ------------------------------------------------------------
	// Input stage with glitch filter
	// ------------------------------------------------------------
	wire rx_raw = rx_sel_reg ? receive_pin_a_i : receive_pin_b_i; // (R7)
	wire [3:0] glitch_w = submode_reg == 2'd1 ? `IRT_GLITCH_SHORT :
		submode_reg == 2'd2 ? `IRT_GLITCH_LONG : 4'h0;
	wire rise_evt = rx_filt_reg && !rx_prev_reg;
	wire fall_evt = !rx_filt_reg && rx_prev_reg;
	wire rise_q = demod && rise_evt && (logic_edge_reg == `IRT_EDGE_RISE || logic_edge_reg == `IRT_EDGE_BOTH);
	wire fall_q = demod && fall_evt && (logic_edge_reg == `IRT_EDGE_FALL || logic_edge_reg == `IRT_EDGE_BOTH);
	wire edge_q = rise_q || fall_q; // (R7)

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pre_reg <= 3'h0;
			glitch_cnt_reg <= 4'h0;
			rx_filt_reg <= 1'b0;
			rx_prev_reg <= 1'b0;
		end else begin
			pre_reg <= pre_reg + 3'h1;
			rx_prev_reg <= rx_filt_reg;
			if (rx_raw == rx_filt_reg) begin
				glitch_cnt_reg <= 4'h0;
			end else if (glitch_cnt_reg + 4'h1 >= glitch_w) begin
				rx_filt_reg <= rx_raw; // (R7)
				glitch_cnt_reg <= 4'h0;
			end else begin
				glitch_cnt_reg <= glitch_cnt_reg + 4'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Counter events
	// ------------------------------------------------------------
	wire wr_short = wr_i && addr_i == {1'b0, `IRT_ADDR_SHORT_CTRL};
	wire wr_shared = wr_i && addr_i == {1'b0, `IRT_ADDR_SHARED_CTRL};
	wire wr_long = wr_i && addr_i == {1'b0, `IRT_ADDR_LONG_CTRL};
	wire wr_sync = wr_i && addr_i == {1'b0, `IRT_ADDR_SYNC_CTRL};
	wire short_run = short_en_reg && (!demod || short_started_reg);
	wire long_run = long_en_reg && (!demod || long_started_reg);
	// Terminal count is reaching 1->0 on a tick; wrap from zero is not expiry. (R12)
	wire short_tc = short_run && short_tick && short_count_reg == {{(SHORT_W-1){1'b0}}, 1'b1};
	wire long_tc = long_run && long_tick && long_count_reg == {{(LONG_W-1){1'b0}}, 1'b1};
	wire short_expiry = short_tc && (demod || short_oneshot_reg || short_phase_reg); // (R10)
	wire long_edge_ok = long_en_reg && (!long_oneshot_reg || long_armed_reg); // (R2)
	wire long_cap_edge = demod && edge_q && long_edge_ok && long_started_reg;
	wire long_cap_tmo = demod && long_oneshot_reg && long_started_reg && short_expiry; // (R20)
	wire short_cap_edge = demod && edge_q && short_en_reg && short_started_reg;

	// ------------------------------------------------------------
	// Short counter
	// ------------------------------------------------------------
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			short_en_reg <= 1'b0;
			short_oneshot_reg <= 1'b0;
			short_tmo_reg <= 1'b0;
			short_pre_reg <= 2'h0;
			short_cap_ie_reg <= 1'b0;
			short_tmo_ie_reg <= 1'b0;
			short_count_reg <= {SHORT_W{1'b0}};
			short_phase_reg <= 1'b0;
			short_started_reg <= 1'b0;
			short_output_o <= 1'b1;
			short_capture_rise_reg <= {SHORT_W{1'b0}};
			short_capture_fall_reg <= {SHORT_W{1'b0}};
			short_irq_reg <= 1'b0;
		end else begin
			short_irq_reg <= (short_expiry && short_tmo_ie_reg) || (short_cap_edge && short_cap_ie_reg);
			if (short_expiry || (wr_short && !wdata_i[`IRT_BIT_TIMEOUT]) || !wr_short) begin
				if (short_expiry)
					short_tmo_reg <= 1'b1; // (R9)
			end else begin
				short_tmo_reg <= 1'b0;
			end
			if (wr_short) begin
				short_oneshot_reg <= wdata_i[`IRT_BIT_ONESHOT];
				short_pre_reg <= wdata_i[4:3];
				short_cap_ie_reg <= wdata_i[`IRT_BIT_CAP_IE];
				short_tmo_ie_reg <= wdata_i[`IRT_BIT_TMO_IE];
			end
			if ((wr_short && wdata_i[`IRT_BIT_ENABLE] && !short_en_reg) ||
				(wr_sync && wdata_i[6] && !short_en_reg) || (alt_mode && long_tc)) begin
				short_en_reg <= 1'b1; // (R21)
				short_started_reg <= 1'b0;
				short_phase_reg <= 1'b0;
				short_output_o <= init_short_reg; // (R8)
				short_count_reg <= demod ? s_ones : (init_short_reg ? short_reload_high_reg : short_reload_low_reg);
			end else if ((wr_short && !wdata_i[`IRT_BIT_ENABLE]) || (wr_sync && !wdata_i[6])) begin
				short_en_reg <= 1'b0;
			end else if (!short_en_reg) begin
				short_output_o <= !init_short_reg; // (R8)
			end else if (demod) begin
				if (edge_q && !short_started_reg) begin
					short_started_reg <= 1'b1; // (R15)
					short_count_reg <= s_ones;
				end else if (short_cap_edge) begin
					if (rise_q)
						short_capture_rise_reg <= ~short_count_reg; // (R15)
					else
						short_capture_fall_reg <= ~short_count_reg;
					short_count_reg <= s_ones;
				end else if (short_run && short_tick) begin
					short_count_reg <= short_count_reg - {{(SHORT_W-1){1'b0}}, 1'b1}; // (R16) (R24)
				end
			end else if (short_tick) begin
				if (short_tc) begin
					short_output_o <= !short_output_o; // (R9)
					if (short_oneshot_reg) begin
						short_count_reg <= {SHORT_W{1'b0}};
						short_en_reg <= 1'b0; // (R21)
					end else begin
						short_phase_reg <= !short_phase_reg; // (R10)
						short_count_reg <= short_output_o ? short_reload_low_reg : short_reload_high_reg; // (R11)
					end
				end else begin
					short_count_reg <= short_count_reg - {{(SHORT_W-1){1'b0}}, 1'b1}; // (R24)
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Long counter
	// ------------------------------------------------------------
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			long_en_reg <= 1'b0;
			long_oneshot_reg <= 1'b0;
			long_tmo_reg <= 1'b0;
			long_prescale_select_reg <= 2'h0;
			long_cap_ie_reg <= 1'b0;
			long_tmo_ie_reg <= 1'b0;
			long_pin_select_reg <= 1'b0;
			long_count_reg <= {LONG_W{1'b0}};
			long_started_reg <= 1'b0;
			long_armed_reg <= 1'b1;
			long_output_o <= 1'b1;
			long_capture_upper_reg <= 8'h00;
			long_capture_lower_reg <= 8'h00;
			long_irq_reg <= 1'b0;
		end else begin
			long_irq_reg <= (long_tc && long_tmo_ie_reg) || ((long_cap_edge || long_cap_tmo) && long_cap_ie_reg); // (R4)
			if (long_tc)
				long_tmo_reg <= 1'b1; // (R3)
			else if (wr_long && wdata_i[`IRT_BIT_TIMEOUT])
				long_tmo_reg <= 1'b0; // (R3)
			if (wr_long) begin
				long_oneshot_reg <= wdata_i[`IRT_BIT_ONESHOT];
				if (!long_oneshot_reg && wdata_i[`IRT_BIT_ONESHOT])
					long_armed_reg <= 1'b1; // (R20)
				long_prescale_select_reg <= wdata_i[4:3];
				long_cap_ie_reg <= wdata_i[`IRT_BIT_CAP_IE];
				long_tmo_ie_reg <= wdata_i[`IRT_BIT_TMO_IE];
				long_pin_select_reg <= wdata_i[`IRT_BIT_PIN_SEL];
			end
			if ((wr_long && wdata_i[`IRT_BIT_ENABLE] && !long_en_reg) ||
				(wr_sync && wdata_i[7] && !long_en_reg) || (alt_mode && short_tc)) begin
				long_en_reg <= 1'b1; // (R21)
				long_started_reg <= 1'b0;
				long_armed_reg <= 1'b1;
				long_output_o <= init_long_reg;
				long_count_reg <= demod ? l_ones : long_reload; // (R18)
			end else if ((wr_long && !wdata_i[`IRT_BIT_ENABLE]) || (wr_sync && !wdata_i[7])) begin
				long_en_reg <= 1'b0;
			end else if (!long_en_reg) begin
				long_output_o <= !init_long_reg; // (R17)
			end else if (demod) begin
				if (edge_q && long_edge_ok && !long_started_reg) begin
					long_started_reg <= 1'b1; // (R19)
					long_count_reg <= l_ones;
					if (long_oneshot_reg)
						long_armed_reg <= 1'b0; // (R20)
				end else if (long_cap_edge) begin
					{long_capture_upper_reg, long_capture_lower_reg} <= ~long_count_reg; // (R19)
					long_count_reg <= l_ones;
					if (long_oneshot_reg)
						long_armed_reg <= 1'b0; // (R2)
				end else if (long_cap_tmo) begin
					{long_capture_upper_reg, long_capture_lower_reg} <= ~long_count_reg; // (R20)
					if (long_tick)
						long_count_reg <= long_count_reg - {{(LONG_W-1){1'b0}}, 1'b1};
				end else if (long_run && long_tick) begin
					long_count_reg <= long_count_reg - {{(LONG_W-1){1'b0}}, 1'b1}; // (R16) (R24)
				end
			end else if (long_tick) begin
				if (long_tc) begin
					long_output_o <= !long_output_o; // (R18)
					if (long_oneshot_reg) begin
						long_count_reg <= {LONG_W{1'b0}}; // (R1)
						long_en_reg <= 1'b0;
					end else begin
						long_count_reg <= long_reload; // (R1) (R11)
					end
				end else begin
					long_count_reg <= long_count_reg - {{(LONG_W-1){1'b0}}, 1'b1}; // (R24)
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Shared control, reloads and edge flags
	// ------------------------------------------------------------
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_reg <= 1'b0;
			rx_sel_reg <= 1'b0;
			logic_edge_reg <= 2'h0;
			submode_reg <= 2'h0;
			init_short_reg <= 1'b0;
			init_long_reg <= 1'b0;
			rise_flag_reg <= 1'b0;
			fall_flag_reg <= 1'b0;
			sync_reg <= 1'b0;
			short_reload_high_reg <= {SHORT_W{1'b0}};
			short_reload_low_reg <= {SHORT_W{1'b0}};
			long_reload_upper_reg <= 8'h00;
			long_reload_lower_reg <= 8'h00;
		end else begin
			if (wr_shared) begin
				mode_reg <= wdata_i[`IRT_BIT_MODE]; // (R23)
				rx_sel_reg <= wdata_i[`IRT_BIT_RX_SEL];
				logic_edge_reg <= wdata_i[5:4];
				submode_reg <= wdata_i[3:2]; // (R21)
				if (!demod) begin
					init_short_reg <= wdata_i[1];
					init_long_reg <= wdata_i[0];
				end
			end
			if (wr_sync)
				sync_reg <= wdata_i[`IRT_BIT_SYNC]; // (R6)
			// Edge flags: a set in the same cycle beats a write-one clear.
			if ((short_cap_edge || long_cap_edge) && rise_q)
				rise_flag_reg <= 1'b1; // (R15)
			else if (wr_shared && demod && wdata_i[1])
				rise_flag_reg <= 1'b0;
			if ((short_cap_edge || long_cap_edge) && fall_q)
				fall_flag_reg <= 1'b1; // (R15)
			else if (wr_shared && demod && wdata_i[0])
				fall_flag_reg <= 1'b0;
			if (wr_i && addr_i == {1'b0, `IRT_ADDR_SHORT_RELOAD_HIGH})
				short_reload_high_reg <= wdata_i[SHORT_W-1:0]; // (R11)
			if (wr_i && addr_i == {1'b0, `IRT_ADDR_SHORT_RELOAD_LOW})
				short_reload_low_reg <= wdata_i[SHORT_W-1:0];
			if (wr_i && addr_i == {1'b0, `IRT_ADDR_LONG_RELOAD_UPPER})
				long_reload_upper_reg <= wdata_i;
			if (wr_i && addr_i == {1'b0, `IRT_ADDR_LONG_RELOAD_LOWER})
				long_reload_lower_reg <= wdata_i;
		end
	end

	// ------------------------------------------------------------
	// Outputs and read port
	// ------------------------------------------------------------
	assign short_irq_o = short_irq_reg;
	assign long_irq_o = long_irq_reg;

	// Forced levels override the long output whether or not it is enabled.
	wire long_pin_level = (!demod && submode_reg == `IRT_SUB_FORCE0) ? 1'b0 :
		(!demod && submode_reg == `IRT_SUB_FORCE1) ? 1'b1 : long_output_o; // (R17)

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			second_timer_pin_o <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			second_timer_pin_o <= long_pin_select_reg ? long_pin_level : port_data_i; // (R5)
			if (rd_i) begin
				case (addr_i)
					{1'b0, `IRT_ADDR_SHORT_CTRL}: rdata_o <= {short_en_reg, short_oneshot_reg, short_tmo_reg,
						short_pre_reg, short_cap_ie_reg, short_tmo_ie_reg, 1'b0};
					{1'b0, `IRT_ADDR_SHARED_CTRL}: rdata_o <= {mode_reg, rx_sel_reg, logic_edge_reg, submode_reg,
						demod ? rise_flag_reg : init_short_reg, demod ? fall_flag_reg : init_long_reg};
					{1'b0, `IRT_ADDR_LONG_CTRL}: rdata_o <= {long_en_reg, long_oneshot_reg, long_tmo_reg,
						long_prescale_select_reg, long_cap_ie_reg, long_tmo_ie_reg, long_pin_select_reg};
					{1'b0, `IRT_ADDR_SYNC_CTRL}: rdata_o <= {long_en_reg, short_en_reg, sync_reg,
						`IRT_SYNC_RESERVED}; // (R6)
					{1'b0, `IRT_ADDR_SHORT_RELOAD_HIGH}: rdata_o <= short_reload_high_reg;
					{1'b0, `IRT_ADDR_SHORT_RELOAD_LOW}: rdata_o <= short_reload_low_reg;
					{1'b0, `IRT_ADDR_LONG_RELOAD_UPPER}: rdata_o <= long_reload_upper_reg;
					{1'b0, `IRT_ADDR_LONG_RELOAD_LOWER}: rdata_o <= long_reload_lower_reg;
					`IRT_ADDR_SHORT_CAP_RISE: rdata_o <= short_capture_rise_reg;
					`IRT_ADDR_SHORT_CAP_FALL: rdata_o <= short_capture_fall_reg;
					`IRT_ADDR_LONG_CAP_UPPER: rdata_o <= long_capture_upper_reg;
					`IRT_ADDR_LONG_CAP_LOWER: rdata_o <= long_capture_lower_reg;
					default: rdata_o <= 8'h00;
				endcase
			end else begin
				rdata_o <= 8'h00;
			end
		end
	end

endmodule
`default_nettype wire

// [test/irt_dual_counter_timer_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module irt_dual_counter_timer_properties (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Register port.
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// Pins.
	input wire logic receive_pin_a_i,
	input wire logic receive_pin_b_i,
	input wire logic port_data_i,
	input wire logic second_timer_pin_o,
	input wire logic short_output_o,
	input wire logic long_output_o,
	// Interrupt requests.
	input wire logic short_irq_o,
	input wire logic long_irq_o
);
	// ----------------------------------------
	// Shadow of the control bits the checks need
	// ----------------------------------------
	logic [2:0] lctl_reg;
	logic [1:0] sie_reg;
	logic [2:0] shared_reg;
	logic sync_reg;
	logic [1:0] settle_reg;
	wire logic forced = lctl_reg[0] && !shared_reg[2] && shared_reg[1];
	wire logic lie = |lctl_reg[2:1];
	wire logic sie = |sie_reg;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lctl_reg <= 3'h0;
			sie_reg <= 2'h0;
			shared_reg <= 3'h0;
			sync_reg <= 1'b0;
			settle_reg <= 2'h0;
		end else begin
			if (wr_i && addr_i == 4'h0) sie_reg <= wdata_i[2:1];
			if (wr_i && addr_i == 4'h1) shared_reg <= {wdata_i[7], wdata_i[3:2]};
			if (wr_i && addr_i == 4'h2) lctl_reg <= wdata_i[2:0];
			if (wr_i && addr_i == 4'h3) sync_reg <= wdata_i[5];
			// Pin routing is judged only once a selection has had time to settle.
			if (wr_i && (addr_i == 4'h1 || addr_i == 4'h2)) settle_reg <= 2'h0;
			else if (settle_reg != 2'h3) settle_reg <= settle_reg + 2'h1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not zero outside a read answer");
	sync_readback_a: assert property ($past(rd_i) && $past(addr_i) == 4'h3 |-> rdata_o[5:0] == {sync_reg, 5'h1F})
		else $error("sync register readback wrong");
	unmapped_zero_a: assert property ($past(rd_i) && $past(addr_i) > 4'hB |-> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	port_route_a: assert property (!lctl_reg[0] && settle_reg == 2'h3 |-> second_timer_pin_o == $past(port_data_i))
		else $error("second pin does not follow port data");
	force_level_a: assert property (forced && settle_reg == 2'h3 |-> second_timer_pin_o == shared_reg[0])
		else $error("second pin not at forced level");
	short_pulse_a: assert property (short_irq_o |=> !short_irq_o)
		else $error("short request longer than one cycle");
	long_pulse_a: assert property (long_irq_o |=> !long_irq_o)
		else $error("long request longer than one cycle");
	long_gate_a: assert property (long_irq_o |-> lie || $past(lie) || $past(lie, 2))
		else $error("long request with both allow bits clear");
	short_gate_a: assert property (short_irq_o |-> sie || $past(sie) || $past(sie, 2))
		else $error("short request with both allow bits clear");
	long_irq_c: cover property (long_irq_o);
	short_irq_c: cover property (short_irq_o);
	forced_c: cover property (forced && settle_reg == 2'h3);
endmodule
`default_nettype wire

// [test/irt_ir_line_model.sv]
`timescale 1ns/1ps
`default_nettype none
module irt_ir_line_model (
	// Clock.
	input wire logic clk_i,
	// Receive lines.
	output logic rx_a_o,
	output logic rx_b_o
);
	logic level_q = 1'b0;
	assign rx_b_o = level_q;
	// The unselected line carries the opposite level, so a wrong pick inverts every edge.
	assign rx_a_o = ~level_q;
	task automatic hold(input logic lvl, input int cycles);
		level_q <= lvl;
		repeat (cycles) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic port_data_i = 1'b0;
	wire [7:0] rdata_o;
	wire second_timer_pin_o, short_output_o, long_output_o, short_irq_o, long_irq_o, rx_a, rx_b;
	int num_errors = 0;
	int n_checks = 0;
	int n;
	int i;
	logic [7:0] d;
	logic [7:0] tg;
	logic o;
	always #12.5 clk_i = ~clk_i;
	irt_dual_counter_timer dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.receive_pin_a_i(rx_a), .receive_pin_b_i(rx_b), .port_data_i, .second_timer_pin_o,
		.short_output_o, .long_output_o, .short_irq_o, .long_irq_o);
	irt_ir_line_model line (.clk_i(clk_i), .rx_a_o(rx_a), .rx_b_o(rx_b));
	// ----------------------------------------
	// Access and compare tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic chkb(input string what, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		v = rdata_o;
		@(posedge clk_i);
	endtask
	task automatic rdchk(input string what, input logic [3:0] a, input logic [7:0] exp);
		rd(a, d);
		chk(what, exp, d);
	endtask
	task automatic wait_irq(input logic lng, input int lim);
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while ((lng ? long_irq_o : short_irq_o) !== 1'b1 && n < lim);
	endtask
	task automatic settle;
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	task automatic stop_test;
		$display("checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdchk("sync reset", 4'h3, 8'h1F);
		wr(4'h3, 8'h20);
		rdchk("sync lockstep", 4'h3, 8'h3F);
		wr(4'h3, 8'h00);
		wr(4'hD, 8'h55);
		rdchk("unmapped", 4'hD, 8'h00);
		wr(4'h1, 8'h00);
		wr(4'h6, 8'h00);
		wr(4'h7, 8'h05);
		chkb("long idle", 1'b1, long_output_o);
		wr(4'h2, 8'hC2);
		chkb("long start level", 1'b0, long_output_o);
		wait_irq(1'b1, 20);
		chkb("long one-shot expiry", 1'b1, n <= 8);
		settle();
		chkb("long toggled", 1'b1, long_output_o);
		rdchk("long halted", 4'h2, 8'h62);
		wr(4'h2, 8'h42);
		rdchk("long flag kept", 4'h2, 8'h62);
		wr(4'h2, 8'h62);
		rdchk("long flag cleared", 4'h2, 8'h42);
		wr(4'h2, 8'h82);
		wait_irq(1'b1, 20);
		wait_irq(1'b1, 20);
		chkb("long reload period", 1'b1, n >= 5 && n <= 6);
		rdchk("long still running", 4'h2, 8'hA2);
		wr(4'h2, 8'h80);
		wait_irq(1'b1, 20);
		chkb("long request masked", 1'b1, n == 20);
		wr(4'h2, 8'h00);
		wr(4'h2, 8'h20);
		wr(4'h1, 8'h02);
		settle();
		chkb("short idle", 1'b0, short_output_o);
		wr(4'h4, 8'h04);
		wr(4'h5, 8'h09);
		wr(4'h0, 8'hCA);
		chkb("short start level", 1'b1, short_output_o);
		wait_irq(1'b0, 20);
		chkb("short one-shot expiry", 1'b1, n >= 6 && n <= 7);
		settle();
		chkb("short toggled", 1'b0, short_output_o);
		rdchk("short halted", 4'h0, 8'h6A);
		wr(4'h0, 8'h20);
		wr(4'h1, 8'h00);
		wr(4'h4, 8'h02);
		wr(4'h5, 8'h03);
		wr(4'h0, 8'h82);
		wait_irq(1'b0, 30);
		tg = 8'h00;
		o = short_output_o;
		do begin
			@(posedge clk_i);
			#1;
			if (short_output_o !== o) tg++;
			o = short_output_o;
		end while (short_irq_o !== 1'b1 && tg < 8'h09);
		chk("short toggles per cycle", 8'h02, tg);
		wr(4'h0, 8'h00);
		wr(4'h0, 8'h20);
		wr(4'h0, 8'h60);
		wr(4'h2, 8'h62);
		wr(4'h1, 8'h04);
		wr(4'h0, 8'hC0);
		wait_irq(1'b1, 30);
		chkb("alternating long expiry", 1'b1, n >= 7 && n <= 8);
		rdchk("alternating hand-off", 4'h3, 8'h5F);
		wr(4'h1, 8'h00);
		wait_irq(1'b1, 30);
		settle();
		rdchk("alternating stopped", 4'h3, 8'h1F);
		wr(4'h2, 8'h01);
		for (i = 2; i < 4; i++) begin
			wr(4'h1, 8'(i << 2));
			settle();
			chkb("forced pin", i[0], second_timer_pin_o);
		end
		wr(4'h1, 8'h00);
		wr(4'h2, 8'h00);
		for (i = 0; i < 2; i++) begin
			port_data_i <= i[0];
			settle();
			chkb("port pin", i[0], second_timer_pin_o);
		end
		for (i = 4; i < 8; i++) wr(i[3:0], 8'hFF);
		wr(4'h1, 8'hA0);
		wr(4'h0, 8'h84);
		wr(4'h2, 8'h84);
		line.hold(1'b1, 20);
		line.hold(1'b0, 30);
		line.hold(1'b1, 10);
		rd(4'h9, d);
		chkb("fall capture", 1'b1, d >= 8'd19 && d <= 8'd21);
		rd(4'h8, d);
		chkb("rise capture", 1'b1, d >= 8'd29 && d <= 8'd31);
		rdchk("long capture upper", 4'hA, 8'h00);
		rd(4'hB, d);
		chkb("long capture lower", 1'b1, d >= 8'd29 && d <= 8'd31);
		rdchk("edge flags", 4'h1, 8'hA3);
		for (i = 0; i < 2; i++) begin
			wr(4'h1, 8'h87 | 8'(i << 4));
			line.hold(1'b0, 2);
			line.hold(1'b1, 10);
			rdchk("glitch filtered", 4'h1, 8'h84 | 8'(i << 4));
			line.hold(1'b0, 10);
			line.hold(1'b1, 10);
			rdchk("edge kind", 4'h1, 8'h84 | 8'(i << 4) | 8'(i + 1));
		end
		stop_test();
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		num_errors++;
		stop_test();
	end
endmodule
bind irt_dual_counter_timer irt_dual_counter_timer_properties props (.clk_i, .rst_i, .addr_i, .wdata_i,
	.wr_i, .rd_i, .rdata_o, .receive_pin_a_i, .receive_pin_b_i, .port_data_i, .second_timer_pin_o,
	.short_output_o, .long_output_o, .short_irq_o, .long_irq_o);
`default_nettype wire
